// file: cmd_word_mem.sv
// Six command words of sixteen bits with a registered read port.
// Assumes one writer per cycle, the sequencer having priority.
`timescale 1ns/1ps
`default_nettype none
module cmd_word_mem (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        reset_n,  // Synchronous reset
  input  wire logic        we,       // Write enable
  input  wire logic [2:0]  waddr,    // Write index
  input  wire logic [15:0] wdata,    // Write data
  input  wire logic [2:0]  raddr,    // Read index
  output logic      [15:0] rdata,    // Registered read data
  output logic      [95:0] flat      // All words, word 0 lowest
);
  logic [15:0] mem_q [6];
  logic [15:0] mem_d [6];
  logic [15:0] rdata_d;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (we && waddr < 3'h6) begin
      mem_d[waddr] = wdata;
    end
    rdata_d = (raddr < 3'h6) ? mem_q[raddr] : 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        mem_q[i] <= 16'h0000;
      end
      rdata <= 16'h0000;
    end else begin
      for (int i = 0; i < 6; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rdata <= rdata_d;
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      flat[i*16 +: 16] = mem_q[i];
    end
  end
endmodule : cmd_word_mem
`default_nettype wire

// file: flash_command_sequencer.sv
// Flash command sequencer: launch checks, memory controller handshake.
// Assumes the memory controller acknowledges each request in time.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic        clk_sys,        // System clock
  input  wire logic        reset_n,        // Synchronous reset
  input  wire logic [3:0]  reg_addr,       // Register address
  input  wire logic [15:0] reg_wdata,      // Write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  output logic      [15:0] reg_rdata,      // Read data, next cycle
  output mem_req_t         mem_req_o,      // Request to controller
  input  wire mem_rsp_t    mem_rsp_i,      // Answer from controller
  input  wire logic        ee_protected,   // Target area protected
  output logic             pflash_blocked, // Program flash reads invalid
  output logic             ee_blocked,     // EEPROM reads invalid
  output logic      [1:0]  security_state  // Current security bits
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  seq_state_t  st_q, st_d;
  logic        cc_q, cc_d;
  logic        acc_q, acc_d;
  logic        mg1_q, mg1_d;
  logic        mg0_q, mg0_d;
  logic [2:0]  idx_q, idx_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [2:0]  last_q, last_d;
  logic [7:0]  op_q, op_d;
  logic [1:0]  sec_q, sec_d;
  logic        key_lock_q, key_lock_d;
  logic        key_ok_q, key_ok_d;
  logic [1:0]  cfg_q, cfg_d;
  logic [15:0] ee_end_q, ee_end_d;
  logic [7:0]  ee_blk_q, ee_blk_d;
  logic [15:0] rd_q, rd_d;
  logic        sel_word_q;
  mem_req_t    req_q, req_d;
  logic        pfb_q, pfb_d;
  logic        eeb_q, eeb_d;

  logic        mw_we;
  logic [2:0]  mw_addr;
  logic [15:0] mw_data;
  logic [15:0] mem_rdata;
  logic [95:0] words;
  logic [15:0] w0, w1;
  logic        launch;
  logic        bad;
  logic [23:0] gaddr;
  logic [17:0] sec_end;

  cmd_word_mem u_words (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .we      (mw_we),
    .waddr   (mw_addr),
    .wdata   (mw_data),
    .raddr   (idx_q),
    .rdata   (mem_rdata),
    .flat    (words)
  );

  assign w0      = words[15:0];
  assign w1      = words[31:16];
  assign gaddr   = {w0[7:0], w1};
  assign sec_end = {2'b00, w1} + {1'b0, words[47:32], 1'b0};
  // Launch: software writes a one to the complete bit while it is set
  assign launch  = reg_wr && reg_addr == ADDR_STATUS
                   && reg_wdata[ST_COMPLETE] && cc_q;

  // ------------------------------------------------------------------
  // Launch checks
  // ------------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    if (!cfg_q[CFG_CMD_AVAIL]) begin
      bad = 1'b1;
    end
    case (w0[15:8])
      OP_READ_ONCE: begin
        if (idx_q != IDX_READ_ONCE) bad = 1'b1;
        if (w1 > RO_MAX_PHRASE) bad = 1'b1;
      end
      OP_VERIFY_EE: begin
        if (idx_q != IDX_VERIFY_EE) bad = 1'b1;
        if (w0[7:0] != ee_blk_q) bad = 1'b1;
        if (gaddr[0]) bad = 1'b1;
        // Section length in words from word two
        if (sec_end > {2'b00, ee_end_q}) begin
          bad = 1'b1;
        end
      end
      OP_PROGRAM_EE: begin
        if (idx_q < IDX_PROG_MIN || idx_q > IDX_PROG_MAX) bad = 1'b1;
        if (w0[7:0] != ee_blk_q || gaddr[0]) bad = 1'b1;
      end
      OP_BACKDOOR: begin
        if (idx_q != IDX_BACKDOOR) bad = 1'b1;
        // A locked or disabled key check is refused outright
        if (key_lock_q || !cfg_q[CFG_KEY_EN]) bad = 1'b1;
      end
      default: bad = 1'b1;
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    cc_d       = cc_q;
    acc_d      = acc_q;
    mg1_d      = mg1_q;
    mg0_d      = mg0_q;
    idx_d      = idx_q;
    cnt_d      = cnt_q;
    last_d     = last_q;
    op_d       = op_q;
    sec_d      = sec_q;
    key_lock_d = key_lock_q;
    key_ok_d   = key_ok_q;
    cfg_d      = cfg_q;
    ee_end_d   = ee_end_q;
    ee_blk_d   = ee_blk_q;
    req_d      = req_q;
    mw_we      = 1'b0;
    mw_addr    = idx_q;
    mw_data    = reg_wdata;
    if (reg_wr && cc_q) begin
      case (reg_addr)
        ADDR_INDEX:    idx_d = reg_wdata[2:0];
        ADDR_WORD:     mw_we = 1'b1;
        ADDR_CONFIG:   cfg_d = reg_wdata[1:0];
        ADDR_EE_END:   ee_end_d = reg_wdata;
        ADDR_EE_BLOCK: ee_blk_d = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[ST_ACCESS_ERR]) begin
      acc_d = 1'b0;
    end
    case (st_q)
      S_IDLE: begin
        if (launch) begin
          mg1_d = 1'b0;
          mg0_d = 1'b0;
          if (bad) begin
            acc_d = 1'b1;
          end else if (!acc_q) begin
            cc_d     = 1'b0;
            op_d     = w0[15:8];
            last_d   = idx_q;
            cnt_d    = 3'h0;
            key_ok_d = 1'b1;
            st_d     = S_REQ;
          end
        end
      end
      S_REQ: begin
        req_d.req   = 1'b1;
        req_d.op    = op_q;
        req_d.addr  = {w0[7:0], w1};
        req_d.wdata = 16'h0000;
        case (op_q)
          OP_READ_ONCE: req_d.addr = {21'h000000, w1[2:0]};
          OP_PROGRAM_EE: begin
            if (ee_protected) begin
              st_d      = S_DONE;
              req_d.req = 1'b0;
            end else begin
              req_d.addr  = gaddr + {20'h00000, cnt_q, 1'b0};
              req_d.wdata = words[(cnt_q + 3'h2)*16 +: 16];
            end
          end
          OP_BACKDOOR: req_d.addr = {21'h000000, cnt_q};
          default: ;
        endcase
        if (st_d == S_REQ) st_d = S_WAIT;
      end
      S_WAIT: begin
        req_d.req = 1'b0;
        if (mem_rsp_i.ack) begin
          mg1_d = mg1_q | mem_rsp_i.err_any;
          mg0_d = mg0_q | mem_rsp_i.err_unc;
          if (op_q == OP_VERIFY_EE && mem_rsp_i.fail) begin
            mg1_d = 1'b1;
            mg0_d = 1'b1;
          end
          if (op_q == OP_PROGRAM_EE && mem_rsp_i.fail) begin
            mg1_d = 1'b1;
          end
          st_d = S_DONE;
          case (op_q)
            OP_READ_ONCE: begin
              mw_we   = 1'b1;
              mw_addr = cnt_q + 3'h2;
              mw_data = mem_rsp_i.rdata;
              if (cnt_q != 3'h3) st_d = S_REQ;
            end
            OP_PROGRAM_EE: begin
              if (cnt_q + 3'h2 != last_q) st_d = S_REQ;
            end
            OP_BACKDOOR: begin
              if (mem_rsp_i.rdata != words[(cnt_q + 3'h1)*16 +: 16]
                  || mem_rsp_i.rdata == KEY_ZERO
                  || mem_rsp_i.rdata == KEY_ONES) begin
                key_ok_d = 1'b0;
              end
              if (cnt_q != 3'h3) st_d = S_REQ;
            end
            default: ;
          endcase
          cnt_d = cnt_q + 3'h1;
        end
      end
      S_DONE: begin
        if (op_q == OP_BACKDOOR) begin
          // Only the live bits change; stored byte is never written
          if (key_ok_q) sec_d = SEC_UNSECURE;
          else key_lock_d = 1'b1;
        end
        cc_d = 1'b1;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Read blocking follows the running command
  always_comb begin
    pfb_d = (st_d != S_IDLE && st_d != S_DONE)
            && (op_d == OP_READ_ONCE || op_d == OP_BACKDOOR);
    eeb_d = (st_d != S_IDLE && st_d != S_DONE)
            && op_d == OP_BACKDOOR;
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_comb begin
    rd_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: begin
          rd_d[ST_COMPLETE]   = cc_q;
          rd_d[ST_ACCESS_ERR] = acc_q;
          rd_d[ST_PROT_VIOL]  = 1'b0;
          rd_d[ST_MARGIN_ANY] = mg1_q;
          rd_d[ST_MARGIN_UNC] = mg0_q;
        end
        ADDR_INDEX:    rd_d = {13'h0000, idx_q};
        ADDR_SECURITY: rd_d = {13'h0000, key_lock_q, sec_q};
        ADDR_CONFIG:   rd_d = {14'h0000, cfg_q};
        ADDR_EE_END:   rd_d = ee_end_q;
        ADDR_EE_BLOCK: rd_d = {8'h00, ee_blk_q};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q       <= S_IDLE;
      cc_q       <= 1'b1;
      acc_q      <= 1'b0;
      mg1_q      <= 1'b0;
      mg0_q      <= 1'b0;
      idx_q      <= 3'h0;
      cnt_q      <= 3'h0;
      last_q     <= 3'h0;
      op_q       <= 8'h00;
      sec_q      <= SEC_RESET;
      key_lock_q <= 1'b0;
      key_ok_q   <= 1'b0;
      cfg_q      <= CFG_RESET;
      ee_end_q   <= EE_END_RESET;
      ee_blk_q   <= EE_BLK_RESET;
      req_q      <= '0;
      rd_q       <= 16'h0000;
      sel_word_q <= 1'b0;
      pfb_q      <= 1'b0;
      eeb_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      cc_q       <= cc_d;
      acc_q      <= acc_d;
      mg1_q      <= mg1_d;
      mg0_q      <= mg0_d;
      idx_q      <= idx_d;
      cnt_q      <= cnt_d;
      last_q     <= last_d;
      op_q       <= op_d;
      sec_q      <= sec_d;
      key_lock_q <= key_lock_d;
      key_ok_q   <= key_ok_d;
      cfg_q      <= cfg_d;
      ee_end_q   <= ee_end_d;
      ee_blk_q   <= ee_blk_d;
      req_q      <= req_d;
      rd_q       <= rd_d;
      sel_word_q <= reg_rd && reg_addr == ADDR_WORD;
      pfb_q      <= pfb_d;
      eeb_q      <= eeb_d;
    end
  end

  // Word reads come from the memory's own output register
  assign reg_rdata      = sel_word_q ? mem_rdata : rd_q;
  assign mem_req_o      = req_q;
  assign pflash_blocked = pfb_q;
  assign ee_blocked     = eeb_q;
  assign security_state = sec_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_launch_bad;
    st_q == S_IDLE && launch && bad;
  endsequence
  property p_abort;
    @(posedge clk_sys) disable iff (!reset_n)
      s_launch_bad |=> acc_q && cc_q && st_q == S_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("bad launch not aborted");
  property p_ro_block;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == S_WAIT && op_q == OP_READ_ONCE) |-> pflash_blocked;
  endproperty
  a_ro_block: assert property (p_ro_block)
    else $error("program flash not blocked");
  property p_key_block;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == S_WAIT && op_q == OP_BACKDOOR) |-> ee_blocked;
  endproperty
  a_key_block: assert property (p_key_block)
    else $error("eeprom not blocked");
  property p_unsec;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == S_DONE && op_q == OP_BACKDOOR && key_ok_q)
      |=> security_state == SEC_UNSECURE;
  endproperty
  a_unsec: assert property (p_unsec)
    else $error("not unsecured");
  property p_lock;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(key_lock_q) |-> $past(key_ok_q) == 1'b0;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock without bad key");
  property p_sec_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      $changed(sec_q) |-> sec_q == SEC_UNSECURE;
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("security bits changed wrongly");
  property p_done;
    @(posedge clk_sys) disable iff (!reset_n)
      st_q == S_DONE |=> cc_q ##1 cc_q || st_q != S_IDLE;
  endproperty
  a_done: assert property (p_done)
    else $error("complete not set");
  property p_prot;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == S_REQ && op_q == OP_PROGRAM_EE && ee_protected)
      |=> !req_q.req;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected area programmed");
  property p_ro_idx;
    @(posedge clk_sys) disable iff (!reset_n)
      (launch && st_q == S_IDLE && w0[15:8] == OP_READ_ONCE
       && idx_q != IDX_READ_ONCE) |=> acc_q;
  endproperty
  a_ro_idx: assert property (p_ro_idx)
    else $error("index error missed");
endmodule : flash_command_sequencer
`default_nettype wire

// file: flash_command_sequencer_test.sv
// Self-checking bench for the flash command sequencer.
// Assumes mem_model on the controller side and the sequencer register map.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_test;
  import flash_seq_pkg::*;
  logic        clk_sys, reset_n, reg_wr, reg_rd, ee_protected, blank_fail;
  logic [3:0]  reg_addr, delay;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [1:0]  security_state, rd_err;
  logic        pflash_blocked, ee_blocked, seen_pf, seen_ee, key_ones;
  logic [7:0]  prog_cnt, c0;
  logic [23:0] prog_addr;
  mem_req_t    mem_req;
  mem_rsp_t    mem_rsp;
  int          err_count, cmp_count;
  // Rows: op, addr hi, word1, word2, index, config, {fail,0,err}, status
  logic [67:0] rows [16] = '{
    68'h04_00_0003_0000_1_2_0_80, 68'h04_00_0003_0000_2_2_0_a0,
    68'h04_00_0008_0000_1_2_0_a0, 68'h04_00_0003_0000_1_0_0_a0,
    68'h04_00_0001_0000_1_2_2_82, 68'h04_00_0001_0000_1_2_3_83,
    68'h12_10_0000_0001_1_2_0_a0, 68'h12_10_0000_0001_2_0_0_a0,
    68'h12_10_0001_0001_2_2_0_a0, 68'h12_20_0000_0001_2_2_0_a0,
    68'h12_10_01fe_0002_2_2_0_a0, 68'h12_10_01fc_0002_2_2_0_80,
    68'h12_10_0000_0001_2_2_8_83, 68'h11_10_0000_1234_6_2_0_a0,
    68'h11_10_0020_1234_2_2_0_80,
    68'h0c_00_1234_5678_4_2_0_a0};

  flash_command_sequencer uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req_o(mem_req),
    .mem_rsp_i(mem_rsp), .ee_protected(ee_protected),
    .pflash_blocked(pflash_blocked), .ee_blocked(ee_blocked),
    .security_state(security_state));
  mem_model far_side (.clk_sys(clk_sys), .reset_n(reset_n), .req_i(mem_req),
    .rsp_o(mem_rsp), .delay(delay), .rd_err(rd_err),
    .blank_fail(blank_fail), .key_ones(key_ones), .prog_cnt(prog_cnt),
    .prog_addr(prog_addr));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (pflash_blocked === 1'b1) seen_pf = 1'b1;
    if (ee_blocked === 1'b1) seen_ee = 1'b1;
  end
  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("mismatches %0d of %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic load(input logic [7:0] op, input logic [7:0] hi,
                      input logic [15:0] w1, input logic [15:0] w2);
    wr(4'h1, 16'h0000);
    wr(4'h2, {op, hi});
    wr(4'h1, 16'h0001);
    wr(4'h2, w1);
    wr(4'h1, 16'h0002);
    wr(4'h2, w2);
  endtask : load
  // Launch with the given index and wait, bounded, for completion
  task automatic go(input logic [2:0] idx);
    int n;
    wr(4'h1, {13'h0000, idx});
    seen_pf = 1'b0;
    seen_ee = 1'b0;
    wr(4'h0, 16'h0080);
    for (n = 0; n < 200; n++) begin
      rd(4'h0, rv);
      if (rv[ST_COMPLETE] === 1'b1) break;
    end
    if (n == 200) begin
      err_count++;
      close_out();
    end
  endtask : go
  task automatic backdoor(input logic [15:0] k3);
    wr(4'h4, 16'h0003);
    load(OP_BACKDOOR, 8'h00, 16'h1234, 16'h5678);
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h9abc);
    wr(4'h1, 16'h0004);
    wr(4'h2, k3);
    go(IDX_BACKDOOR);
  endtask : backdoor
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, ee_protected, blank_fail, key_ones} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    delay = 4'h2;
    rd_err = 2'h0;
    {seen_pf, seen_ee, err_count, cmp_count} = '0;
    do_reset();
    rd(4'h0, rv); check(rv, 16'h0080);
    rd(4'h3, rv); check(rv, 16'h0003);
    rd(4'h4, rv); check(rv, 16'h0002);
    rd(4'h5, rv); check(rv, 16'h0200);
    rd(4'h6, rv); check(rv, 16'h0010);
    rd(4'hf, rv); check(rv, 16'h0000);
    foreach (rows[i]) begin
      wr(4'h4, {12'h000, rows[i][15:12]});
      rd_err     <= rows[i][9:8];
      blank_fail <= rows[i][11];
      load(rows[i][67:60], rows[i][59:52], rows[i][51:36], rows[i][35:20]);
      go(rows[i][18:16]);
      check(rv, {8'h00, rows[i][7:0]});
      check({15'h0000, rv[ST_PROT_VIOL]}, 16'h0000);
      check(rv & 16'h0020, {8'h00, rows[i][7:0] & 8'h20});
      wr(4'h0, 16'h0020);
    end
    {rd_err, blank_fail} <= 3'h0;
    delay <= 4'h6;
    wr(4'h4, 16'h0002);
    load(OP_READ_ONCE, 8'h00, 16'h0007, 16'h0000);
    go(IDX_READ_ONCE);
    check(seen_pf, 1'b1);
    for (int w = 2; w < 6; w++) begin
      wr(4'h1, w[15:0]);
      rd(4'h2, rv);
      check(rv, 16'h5a07);
    end
    // A failed program verify raises the any-error margin flag
    blank_fail <= 1'b1;
    load(OP_PROGRAM_EE, 8'h10, 16'h0030, 16'h7777);
    go(3'h2);
    check(rv, 16'h0082);
    blank_fail <= 1'b0;
    // Fresh erased EEPROM words only; no flash phrase is programmed
    c0 = prog_cnt;
    load(OP_PROGRAM_EE, 8'h10, 16'h0040, 16'h1111);
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h2222);
    wr(4'h1, 16'h0004);
    wr(4'h2, 16'h3333);
    go(3'h4);
    check({8'h00, prog_cnt - c0}, 16'h0003);
    check(prog_addr[15:0], 16'h0044);
    check(rv, 16'h0080);
    ee_protected <= 1'b1;
    load(OP_PROGRAM_EE, 8'h10, 16'h0060, 16'h4444);
    go(3'h2);
    check({8'h00, prog_cnt - c0}, 16'h0003);
    ee_protected <= 1'b0;
    load(OP_PROGRAM_EE, 8'h10, 16'h0070, 16'h5555);
    go(3'h7);
    check({8'h00, prog_cnt - c0}, 16'h0003);
    wr(4'h0, 16'h0020);
    backdoor(16'hdef0);
    check({14'h0000, security_state}, 16'h0002);
    check({seen_pf, seen_ee}, 2'h3);
    check({8'h00, prog_cnt - c0}, 16'h0003);
    do_reset();
    check({14'h0000, security_state}, 16'h0003);
    // Stored and presented keys agree, but all ones is forbidden
    key_ones <= 1'b1;
    backdoor(16'hffff);
    key_ones <= 1'b0;
    rd(4'h3, rv);
    check(rv, 16'h0007);
    wr(4'h0, 16'h0020);
    backdoor(16'hdef0);
    check(rv, 16'h00a0);
    check({14'h0000, security_state}, 16'h0003);
    do_reset();
    backdoor(16'hdef0);
    check({14'h0000, security_state}, 16'h0002);
    close_out();
  end
endmodule : flash_command_sequencer_test
`default_nettype wire

// file: flash_seq_pkg.sv
// Constants, types and command codes for the flash command sequencer.
// Assumes a single 10 MHz system clock and a plain register port.
package flash_seq_pkg;
  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_INDEX     = 4'h1;
  localparam logic [3:0] ADDR_WORD      = 4'h2;
  localparam logic [3:0] ADDR_SECURITY  = 4'h3;
  localparam logic [3:0] ADDR_CONFIG    = 4'h4;
  localparam logic [3:0] ADDR_EE_END    = 4'h5;
  localparam logic [3:0] ADDR_EE_BLOCK  = 4'h6;
  // Status field positions
  localparam int ST_COMPLETE   = 7;
  localparam int ST_ACCESS_ERR = 5;
  localparam int ST_PROT_VIOL  = 4;
  localparam int ST_MARGIN_ANY = 1;
  localparam int ST_MARGIN_UNC = 0;
  // Config field positions
  localparam int CFG_KEY_EN    = 0;
  localparam int CFG_CMD_AVAIL = 1;
  // ------------------------------------------------------------------
  // Command codes and limits
  // ------------------------------------------------------------------
  localparam logic [7:0]  OP_READ_ONCE  = 8'h04;
  localparam logic [7:0]  OP_VERIFY_EE  = 8'h12;
  localparam logic [7:0]  OP_PROGRAM_EE = 8'h11;
  localparam logic [7:0]  OP_BACKDOOR   = 8'h0c;
  localparam logic [15:0] RO_MAX_PHRASE = 16'h0007;
  localparam int          RO_PHRASES    = 8;
  localparam int          RO_BYTES      = 64;
  localparam logic [2:0]  IDX_READ_ONCE = 3'h1;
  localparam logic [2:0]  IDX_VERIFY_EE = 3'h2;
  localparam logic [2:0]  IDX_BACKDOOR  = 3'h4;
  localparam logic [2:0]  IDX_PROG_MIN  = 3'h2;
  localparam logic [2:0]  IDX_PROG_MAX  = 3'h5;
  localparam logic [15:0] KEY_ZERO      = 16'h0000;
  localparam logic [15:0] KEY_ONES      = 16'hffff;
  localparam logic [1:0]  SEC_UNSECURE  = 2'h2;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  SEC_RESET     = 2'h3;
  localparam logic [15:0] EE_END_RESET  = 16'h0200;
  localparam logic [7:0]  EE_BLK_RESET  = 8'h10;
  localparam logic [1:0]  CFG_RESET     = 2'h2;

  typedef enum {S_IDLE, S_REQ, S_WAIT, S_DONE} seq_state_t;

  typedef struct packed {
    logic        req;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic        err_any;
    logic        err_unc;
    logic        fail;
  } mem_rsp_t;
endpackage : flash_seq_pkg

// file: mem_model.sv
// Behavioural memory controller with fixed stored keys for the sequencer bench.
// Assumes one request at a time; ack delay and error classes set by bench.
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import flash_seq_pkg::*;
(
  input  wire logic        clk_sys,    // System clock
  input  wire logic        reset_n,    // Synchronous reset
  input  wire mem_req_t    req_i,      // Request from sequencer
  output mem_rsp_t         rsp_o,      // Answer to sequencer
  input  wire logic [3:0]  delay,      // Ack delay in cycles
  input  wire logic [1:0]  rd_err,     // {any, uncorrectable}
  input  wire logic        blank_fail, // Blank check fails
  input  wire logic        key_ones,   // Stored key three reads ones
  output logic      [7:0]  prog_cnt,   // Program requests seen
  output logic      [23:0] prog_addr   // Last program address
);
  // Stored keys, read only here so a key check cannot alter them
  localparam logic [63:0] KEYS = 64'hdef0_9abc_5678_1234;
  logic [3:0] wait_q;
  logic       busy_q;
  mem_req_t   cur_q;
  logic [15:0] key_word;
  // All-ones stored key lets the bench reach the forbidden-key path
  assign key_word = (key_ones && cur_q.addr[1:0] == 2'h3) ? 16'hffff
                    : KEYS[16*cur_q.addr[1:0] +: 16];
  // ------------------------------------------------------------------
  // Request and answer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_q   <= 1'b0;
      wait_q   <= 4'h0;
      cur_q    <= '0;
      rsp_o    <= '0;
      prog_cnt <= 8'h00;
      prog_addr <= 24'h000000;
    end else begin
      rsp_o.ack   <= 1'b0;
      // Idle data keep changing so stale values never look valid
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.req) begin
        busy_q <= 1'b1;
        wait_q <= delay;
        cur_q  <= req_i;
        if (req_i.op == OP_PROGRAM_EE) begin
          prog_cnt  <= prog_cnt + 8'h01;
          prog_addr <= req_i.addr;
        end
      end else if (busy_q && wait_q == 4'h0) begin
        busy_q        <= 1'b0;
        rsp_o.ack     <= 1'b1;
        rsp_o.rdata   <= (cur_q.op == OP_BACKDOOR) ?
                         key_word :
                         {8'h5a, cur_q.addr[7:0]};
        rsp_o.err_any <= rd_err[1];
        rsp_o.err_unc <= rd_err[0];
        rsp_o.fail    <= blank_fail;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : mem_model
`default_nettype wire
